// file: test/host_model.sv
// Host model: drives serial clock, data, write select and load strobe.
// Assumes mclk_in runs; pins change only at its falling edge.
`timescale 1ns/1ps
module host_model (
  input wire logic mclk_in,
  output logic sclk_out,
  output logic sdata_out,
  output logic write_n_out,
  output logic latch_strobe_out
);
  initial begin
    sclk_out = 1'b0;
    sdata_out = 1'b0;
    write_n_out = 1'b1;
    latch_strobe_out = 1'b1;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk_in);
  endtask : wait_n
  // Five mclk per phase keeps sclk at 1 MHz
  task automatic shift(input logic [15:0] v, input int n, input logic sel_n);
    write_n_out = sel_n;
    latch_strobe_out = sel_n;
    for (int i = n - 1; i >= 0; i--) begin
      wait_n(5);
      sclk_out = 1'b0;
      sdata_out = v[i];
      wait_n(5);
      sclk_out = 1'b1;
    end
    wait_n(5);
    sclk_out = 1'b0;
    // Released data line must not keep its last value
    sdata_out = ~sdata_out;
  endtask : shift
  task automatic latch();
    wait_n(5);
    write_n_out = 1'b1;
    latch_strobe_out = 1'b1;
    wait_n(10);
  endtask : latch
endmodule : host_model

// file: test/serial_mixer_control_bench.sv
// Bench for the serial mixer control: random and corner address/data bytes.
// Assumes host_model drives the serial pins; expectations kept here.
`timescale 1ns/1ps
module serial_mixer_control_bench;
  import mixer_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic mute_in = 1'b0;
  wire logic sclk, sdata, write_n, strobe, dout;
  logic [7:0] left, right, exp_l, exp_r, a, d;
  logic [47:0] atten, exp_a;
  logic [2:0] sel, exp_s;
  logic [15:0] v;
  int errors = 0;
  int comparisons = 0;
  initial begin
    forever #50 mclk_in = ~mclk_in;
  end
  host_model host (.mclk_in(mclk_in), .sclk_out(sclk), .sdata_out(sdata), .write_n_out(write_n),
    .latch_strobe_out(strobe));
  serial_mixer_control DUT (.mclk_in(mclk_in), .rst_in(rst_in), .sclk_in(sclk), .sdata_in(sdata),
    .write_n_in(write_n), .latch_strobe_in(strobe), .mute_in(mute_in), .sdata_out(dout),
    .left_en_out(left), .right_en_out(right), .atten_out(atten), .sel_chan_out(sel));
  function automatic void apply(input logic [7:0] b);
    if (b[ADDR_FLAG_BIT]) begin
      exp_s = b[2:0];
      exp_l[b[2:0]] = b[LEFT_BIT];
      exp_r[b[2:0]] = b[RIGHT_BIT];
    end else begin
      exp_a[exp_s*ATTEN_W +: ATTEN_W] = b[5:0];
    end
  endfunction : apply
  task automatic check_state();
    comparisons++;
    if ({left, right, atten, sel} !== {exp_l & {8{!mute_in}}, exp_r & {8{!mute_in}}, exp_a, exp_s}) begin
      errors++;
      $display("CHECK FAILED %0t channel state mismatch", $time);
    end
  endtask : check_state
  task automatic check_bit(input logic exp);
    comparisons++;
    if (dout !== exp) begin
      errors++;
      $display("CHECK FAILED %0t serial output mismatch", $time);
    end
  endtask : check_bit
  task automatic send(input logic [7:0] b);
    host.shift({8'h00, b}, 8, 1'b0);
    check_state();
    check_bit(b[7]);
    host.latch();
    apply(b);
    check_state();
  endtask : send
  task automatic report_and_stop();
    if (errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    void'($urandom(32'hADB96C5C));
    exp_l = '0;
    exp_r = '0;
    exp_a = '0;
    exp_s = '0;
    // Reset loads idle pin levels into the sync flops at once
    repeat (3) @(negedge mclk_in);
    rst_in = 1'b0;
    check_state();
    for (int k = 0; k < 12; k++) begin
      a = (k == 0) ? 8'h9F : (k == 1) ? 8'h80 : {1'b1, 7'($urandom)};
      send(a);
      for (int j = 0; j < 2; j++) begin
        d = (k == 0) ? 8'h3F : (k == 1) ? 8'h00 : {1'b0, 7'($urandom)};
        send(d);
      end
    end
    @(negedge mclk_in);
    mute_in = 1'b1;
    #1 check_state();
    host.wait_n(3);
    mute_in = 1'b0;
    host.wait_n(2);
    check_state();
    send(8'h9A);
    host.shift(16'h0000, 8, 1'b1);
    host.latch();
    check_bit(1'b1);
    check_state();
    v = {1'b0, 7'($urandom), 1'b1, 7'($urandom)};
    host.shift({8'h00, v[15:8]}, 8, 1'b0);
    check_bit(v[15]);
    host.shift({8'h00, v[7:0]}, 8, 1'b0);
    check_bit(v[7]);
    host.latch();
    apply(v[7:0]);
    check_state();
    report_and_stop();
  end
  initial begin
    #2_000_000;
    errors++;
    report_and_stop();
  end
endmodule : serial_mixer_control_bench

// file: verilog/mixer_pkg.sv
// Shared constants for the serial mixer control logic.
// Assumes a single 10 MHz system clock sampling the slow serial pins.
package mixer_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int SCLK_MAX_HZ = 1_000_000;
  // Fewest system clocks per serial clock period at the fastest legal rate
  localparam int SCLK_MIN_CYCLES = CLK_HZ / SCLK_MAX_HZ;
  localparam int NUM_CHAN = 8;
  localparam int CHAN_W = 3;
  localparam int BYTE_W = 8;
  localparam int ATTEN_W = 6;
  localparam int ATTEN_STEP_DB = 1;
  localparam int ATTEN_MAX_DB = 63;
  // Byte layout
  localparam int ADDR_FLAG_BIT = 7;
  localparam int CHAN_LSB = 0;
  localparam int LEFT_BIT = 3;
  localparam int RIGHT_BIT = 4;
  localparam int ATTEN_LSB = 0;
  // Reset values
  localparam logic [BYTE_W-1:0] SHIFT_RST = 8'h00;
  localparam logic [CHAN_W-1:0] CHAN_RST = 3'h0;
  localparam logic [ATTEN_W-1:0] ATTEN_RST = 6'h00;
  localparam logic [NUM_CHAN-1:0] SWITCH_RST = 8'h00;
  // Idle pin levels {strobe, select, clock, data}: clock low, select and strobe high, data low
  localparam logic [3:0] PINS_IDLE = 4'hC;
endpackage : mixer_pkg

// file: verilog/pin_sync.sv
// Three-flop synchroniser with agreement filter for slow pin inputs.
// Assumes the pins change far slower than the sampling clock.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Pins and filtered levels
  input wire logic [W-1:0] pins_in,
  output logic [W-1:0] level_out
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      wire agree = (s2[i] == s3[i]);
      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          s1[i] <= RST_VAL[i];
          s2[i] <= RST_VAL[i];
          s3[i] <= RST_VAL[i];
          level_out[i] <= RST_VAL[i];
        end else begin
          s1[i] <= pins_in[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          // A change counts only once two stages agree
          if (agree) begin
            level_out[i] <= s3[i];
          end
        end
      end
    end
  endgenerate
endmodule : pin_sync

// file: verilog/serial_mixer_control.sv
// Serial control of an eight-input, two-output mixer: shift register, latch, register banks.
// Assumes serial pins are asynchronous to mclk_in and toggle at 1 MHz or slower.
//
// Contract
// - Shift only while write select is low
// - Sample data on sclk rise, MSB first
// - Banks change only on latch strobe rise
// - MSB set: address byte sets channel, switches
// - MSB clear: six bits to selected attenuator
// - Attenuation code is linear, 1 dB steps
// - Selected channel kept for following data bytes
// - Two banks of eight per-channel registers
// - Mute silences all channels asynchronously
// - Mute preserves stored attenuation codes
// - Mute release restores enables from stored switch bits
// - Serial output shows shift register MSB
// - Left and right switches are independent
// - Chained devices latch together after sixteen bits
// - Serial output updates on sclk rise
`timescale 1ns/1ps
module serial_mixer_control
  import mixer_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Serial pins and mute input
  input wire logic sclk_in,
  input wire logic sdata_in,
  input wire logic write_n_in,
  input wire logic latch_strobe_in,
  input wire logic mute_in,
  // Daisy chain output
  output logic sdata_out,
  // Channel control
  output logic [NUM_CHAN-1:0] left_en_out,
  output logic [NUM_CHAN-1:0] right_en_out,
  output logic [NUM_CHAN*ATTEN_W-1:0] atten_out,
  output logic [CHAN_W-1:0] sel_chan_out
);
  logic [3:0] pin_level;
  logic sclk_prev;
  logic latch_prev;
  logic [BYTE_W-1:0] shift_reg;
  logic [NUM_CHAN-1:0] left_sw;
  logic [NUM_CHAN-1:0] right_sw;
  logic [ATTEN_W-1:0] atten [NUM_CHAN];

  pin_sync #(
    .W(4),
    .RST_VAL(PINS_IDLE)
  ) u_sync (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .pins_in({latch_strobe_in, write_n_in, sclk_in, sdata_in}),
    .level_out(pin_level)
  );

  // Filtered levels lag the pins by four edges, so each serial phase needs five
  wire sd_f = pin_level[0];
  wire sclk_f = pin_level[1];
  wire wr_n_f = pin_level[2];
  wire ld_f = pin_level[3];
  wire sclk_rise = sclk_f & ~sclk_prev;
  wire ld_rise = ld_f & ~latch_prev;
  wire do_shift = sclk_rise & ~wr_n_f;
  wire [BYTE_W-1:0] next_shift = {shift_reg[BYTE_W-2:0], sd_f};
  wire is_addr = shift_reg[ADDR_FLAG_BIT];
  wire [CHAN_W-1:0] addr_chan = shift_reg[CHAN_LSB +: CHAN_W];
  wire [ATTEN_W-1:0] data_code = shift_reg[ATTEN_LSB +: ATTEN_W];
  wire do_addr = ld_rise & is_addr;
  wire do_data = ld_rise & ~is_addr;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_prev <= 1'b0;
      latch_prev <= 1'b1;
    end else begin
      sclk_prev <= sclk_f;
      latch_prev <= ld_f;
    end
  end

  // Chained parts see our MSB; the strobe rise latches every part at once
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      shift_reg <= SHIFT_RST;
      sdata_out <= 1'b0;
    end else if (do_shift) begin
      shift_reg <= next_shift;
      sdata_out <= next_shift[BYTE_W-1];
    end
  end

  // Switch bank and channel select; updated only by an address byte
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      left_sw <= SWITCH_RST;
      right_sw <= SWITCH_RST;
      sel_chan_out <= CHAN_RST;
    end else if (do_addr) begin
      sel_chan_out <= addr_chan;
      left_sw[addr_chan] <= shift_reg[LEFT_BIT];
      right_sw[addr_chan] <= shift_reg[RIGHT_BIT];
    end
  end

  // Attenuator bank; code n means n dB of attenuation. Untouched by mute.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        atten[c] <= ATTEN_RST;
      end
    end else if (do_data) begin
      atten[sel_chan_out] <= data_code;
    end
  end

  // Mute clears the enables without waiting for a clock edge
  // Release is not synchronised; a late edge only delays re-enable by one cycle
  always_ff @(posedge mclk_in or posedge rst_in or posedge mute_in) begin
    if (rst_in || mute_in) begin
      left_en_out <= SWITCH_RST;
      right_en_out <= SWITCH_RST;
    end else begin
      left_en_out <= left_sw;
      right_en_out <= right_sw;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_atten
      assign atten_out[g*ATTEN_W +: ATTEN_W] = atten[g];
    end
  endgenerate

  chk_shift_gate: assert property (@(posedge mclk_in) disable iff (rst_in)
    wr_n_f |=> $stable(shift_reg))
    else $error("shift register moved while write select high");

  chk_shift_order: assert property (@(posedge mclk_in) disable iff (rst_in)
    do_shift |=> shift_reg == {$past(shift_reg[BYTE_W-2:0]), $past(sd_f)})
    else $error("shift register did not take serial bit at LSB");

  chk_bank_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
    !ld_rise |=> $stable(left_sw) && $stable(right_sw) && $stable(atten_out))
    else $error("register bank changed without a strobe rise");

  chk_addr_decode: assert property (@(posedge mclk_in) disable iff (rst_in)
    do_addr |=> sel_chan_out == $past(addr_chan)
      && left_sw[sel_chan_out] == $past(shift_reg[LEFT_BIT])
      && right_sw[sel_chan_out] == $past(shift_reg[RIGHT_BIT]))
    else $error("address byte decoded wrongly");

  chk_data_write: assert property (@(posedge mclk_in) disable iff (rst_in)
    do_data |=> atten[$past(sel_chan_out)] == $past(data_code))
    else $error("data byte not written to selected attenuator");

  chk_sel_keep: assert property (@(posedge mclk_in) disable iff (rst_in)
    do_data |=> $stable(sel_chan_out) && $stable(left_sw))
    else $error("data byte disturbed channel selection");

  chk_mute_silence: assert property (@(posedge mclk_in) disable iff (rst_in)
    mute_in |-> left_en_out == '0 && right_en_out == '0)
    else $error("channel enabled during mute");

  chk_mute_keep: assert property (@(posedge mclk_in) disable iff (rst_in)
    mute_in && !ld_rise |=> $stable(atten_out))
    else $error("attenuation changed by mute");

  chk_route_follow: assert property (@(posedge mclk_in) disable iff (rst_in)
    !mute_in ##1 !mute_in |-> left_en_out == $past(left_sw) && right_en_out == $past(right_sw))
    else $error("enables do not follow switch bits");

  chk_chain_out: assert property (@(posedge mclk_in) disable iff (rst_in)
    sdata_out == shift_reg[BYTE_W-1])
    else $error("serial output differs from shift register MSB");

  // Serial output may move only while write select is low
  chk_chain_gate: assert property (@(posedge mclk_in) disable iff (rst_in)
    wr_n_f |=> $stable(sdata_out))
    else $error("serial output moved while write select high");

  chk_shift_idle: assert property (@(posedge mclk_in) disable iff (rst_in)
    !do_shift |=> $stable(shift_reg))
    else $error("shift register moved without a serial clock rise");

  chk_chain_update: assert property (@(posedge mclk_in) disable iff (rst_in)
    !do_shift |=> $stable(sdata_out))
    else $error("serial output changed off a serial clock rise");

  chk_switch_only_addr: assert property (@(posedge mclk_in) disable iff (rst_in)
    !do_addr |=> $stable(left_sw) && $stable(right_sw))
    else $error("switch bank changed without an address byte");

  chk_atten_only_data: assert property (@(posedge mclk_in) disable iff (rst_in)
    !do_data |=> $stable(atten_out))
    else $error("attenuator bank changed without a data byte");

  chk_sel_only_addr: assert property (@(posedge mclk_in) disable iff (rst_in)
    !do_addr |=> $stable(sel_chan_out))
    else $error("channel selection changed without an address byte");

  chk_switch_one: assert property (@(posedge mclk_in) disable iff (rst_in)
    do_addr |=> $countones(left_sw ^ $past(left_sw)) <= 1 && $countones(right_sw ^ $past(right_sw)) <= 1)
    else $error("address byte touched more than one channel");

  chk_enable_mask: assert property (@(posedge mclk_in) disable iff (rst_in)
    (left_en_out & ~$past(left_sw)) == '0 && (right_en_out & ~$past(right_sw)) == '0)
    else $error("channel enabled without its switch bit");

  chk_addr_enable: assert property (@(posedge mclk_in) disable iff (rst_in)
    do_addr ##1 !mute_in ##1 !mute_in |-> left_en_out == left_sw && right_en_out == right_sw)
    else $error("address byte did not enable channel at once");

  chk_reset_clear: assert property (@(posedge mclk_in) disable iff (rst_in)
    $fell(rst_in) |-> left_sw == SWITCH_RST && right_sw == SWITCH_RST && sel_chan_out == CHAN_RST)
    else $error("switches or selection not cleared by reset");

endmodule : serial_mixer_control
